/* shared/cbi_pkg.sv */
package cbi_pkg;

    // Timebase and blanking figures
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned PWM_HZ = 20000;
    localparam int unsigned PWM_DIV = CLK_HZ / PWM_HZ;
    localparam logic [1:0] BLANK_CYCLES = 2'h2;
    localparam logic [1:0] LOCK_CYCLES = 2'h2;
    localparam int unsigned TACH_TIME_US = 140;
    localparam int unsigned TACH_CYCLES = (TACH_TIME_US * (CLK_HZ / 1000000));

    // Drive bit positions within a six-bit drive word
    localparam int unsigned LS_A = 0;
    localparam int unsigned LS_B = 1;
    localparam int unsigned LS_C = 2;
    localparam int unsigned HS_A = 3;
    localparam int unsigned HS_B = 4;
    localparam int unsigned HS_C = 5;

    // Drive word with every switch off, phase-active sense
    localparam logic [5:0] DRIVE_OFF = 6'h00;

    // Position sensor code, sensor 1 in the top bit
    typedef struct packed {
        logic position_sensor_1;
        logic position_sensor_2;
        logic position_sensor_3;
    } cbi_hall_t;

    // Drive word, 1 means the switch is to be on
    typedef struct packed {
        logic [2:0] hs_on;
        logic [2:0] ls_on;
    } cbi_drive_t;

endpackage

/* logic/cbi_lockout.sv */
`timescale 1ns/10ps
// One cross-conduction lockout flop per drive output
module cbi_lockout
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Timebase
    input wire logic pwm_tick,
    // Requested and granted drive
    input wire logic [5:0] req_on,
    output logic [5:0] drive_on,
    output logic [5:0] lock_set
);

    typedef struct packed {
        logic [5:0] lock;
        logic [5:0][1:0] cnt;
        logic [5:0] on;
    } cbi_lock_st_t;

    cbi_lock_st_t s_q, s_d;

    // Opposing output of the same phase
    function automatic int unsigned opp(input int unsigned i);
        return (i < 3) ? i + 3 : i - 3;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // A drive turns on only when the opposite flop is clear
    always_comb
    begin
        s_d = s_q;
        for (int unsigned i = 0; i < 6; i++)
        begin
            s_d.on[i] = req_on[i] & ~s_q.lock[opp(i)] & ~s_q.on[opp(i)];
            if (s_q.on[i])
            begin
                s_d.lock[i] = 1'b1;
                s_d.cnt[i] = 2'h0;
            end
            else if (s_q.lock[i] && pwm_tick)
            begin
                // Count every tick after turn-off, a partial first period included
                if (s_q.cnt[i] == cbi_pkg::LOCK_CYCLES - 2'h1)
                    s_d.lock[i] = 1'b0;
                else
                    s_d.cnt[i] = s_q.cnt[i] + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign drive_on = s_q.on;
    assign lock_set = s_q.lock;

    //////////////////////////////////////////////////////////////////////
    a_no_overlap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (drive_on[2:0] & drive_on[5:3]) == 3'h0)
        else $error("high and low side of a phase on together");
    a_lock_follows_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
        drive_on[0] |=> lock_set[0])
        else $error("lockout not set after drive on");
    a_lock_blocks_opp: assert property (@(posedge clk_sys) disable iff (!arst_n)
        lock_set[0] |=> !drive_on[3])
        else $error("opposing drive on while locked");
    a_lock_holds_tick: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(drive_on[1]) ##1 !pwm_tick |=> lock_set[1])
        else $error("lockout cleared without a timebase tick");

endmodule

/* logic/cbi_top.sv */
`timescale 1ns/10ps
// Operation
// - Sensor latches pass the sensors through and capture at once on a transition.
// - After a capture the latches stay closed until both the second PWM timebase tick and the end of the tach pulse.
// - Six lockout flops, each set whenever its drive is switched on.
// - A lockout flop clears only on the second timebase tick after its drive goes off.
// - A set lockout flop inhibits the opposite drive of the same phase.
// - Each valid code and direction turns on exactly one low and one high side drive.
// - Codes all-low or all-high turn every drive off regardless of direction.
// - A sensor change loads the latches and fires a fixed tach pulse that blocks loading.
module cbi_top #(
    parameter int unsigned PWM_DIV = cbi_pkg::PWM_DIV,
    parameter int unsigned TACH_CYCLES = cbi_pkg::TACH_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Sensors and direction
    input cbi_pkg::cbi_hall_t hall,
    input wire logic dir_fwd,
    // Drives; low side active high, high side active low (pull low = on)
    output logic [2:0] low_side_drive,
    output logic [2:0] high_side_drive_n,
    // Status
    output logic tach_out,
    output cbi_pkg::cbi_hall_t hall_held
);

    typedef struct packed {
        logic [15:0] div;
        logic [1:0] blank;
        logic [15:0] tach;
        logic [2:0] held;
        logic held_ok;
        logic [5:0] req;
    } cbi_st_t;

    cbi_st_t s_q, s_d;
    logic tick;
    logic [5:0] drive_on;

    // Commutation decode: {hs_c,hs_b,hs_a,ls_c,ls_b,ls_a}
    function automatic logic [5:0] decode(input logic [2:0] h, input logic fwd);
        logic [5:0] r;
        r = cbi_pkg::DRIVE_OFF;
        unique case ({fwd, h})
            // Forward rotation
            4'h9: r = 6'h0a;
            4'hb: r = 6'h0c;
            4'ha: r = 6'h14;
            4'he: r = 6'h11;
            4'hc: r = 6'h21;
            4'hd: r = 6'h22;
            // Reverse rotation
            4'h5: r = 6'h14;
            4'h4: r = 6'h0c;
            4'h6: r = 6'h0a;
            4'h2: r = 6'h22;
            4'h3: r = 6'h21;
            4'h1: r = 6'h11;
            default: r = cbi_pkg::DRIVE_OFF;
        endcase
        return r;
    endfunction

    // Codes with every sensor equal never occur on a healthy rotor
    function automatic logic code_ok(input logic [2:0] h);
        return (h != 3'h0) && (h != 3'h7);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Timebase, blanking, tach and position latches
    always_comb
    begin
        s_d = s_q;
        tick = (s_q.div == 16'(PWM_DIV - 1));
        s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;
        if (s_q.tach != 16'h0000)
            s_d.tach = s_q.tach - 16'h0001;
        if (s_q.blank != 2'h0 && tick)
            s_d.blank = s_q.blank - 2'h1;
        // Latch is transparent while open; tach high also holds it shut
        if (hall != s_q.held && s_q.blank == 2'h0 && s_q.tach == 16'h0000)
        begin
            s_d.held = hall;
            s_d.blank = cbi_pkg::BLANK_CYCLES;
            s_d.tach = 16'(TACH_CYCLES);
            s_d.held_ok = 1'b1;
        end
        // Drives follow only the held code, never the raw sensors
        s_d.req = s_q.held_ok ? decode(s_q.held, dir_fwd) : cbi_pkg::DRIVE_OFF;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    //////////////////////////////////////////////////////////////////////
    cbi_lockout u_lock (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pwm_tick(tick),
        .req_on(s_q.req),
        .drive_on(drive_on),
        .lock_set()
    );

    // Output pins: drives from the lockout flops, tach and held code from the latch state
    assign low_side_drive = drive_on[2:0];
    assign high_side_drive_n = ~drive_on[5:3];
    assign tach_out = (s_q.tach != 16'h0000);
    assign hall_held = s_q.held;

    //////////////////////////////////////////////////////////////////////
    a_latch_frozen: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.blank != 2'h0) |=> $stable(s_q.held))
        else $error("position latch moved while blanked");
    a_capture_now: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (hall != s_q.held && s_q.blank == 2'h0 && !tach_out) |=> s_q.held == $past(hall))
        else $error("transition not captured at once");
    a_tach_fires: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(s_q.held) |-> tach_out)
        else $error("no tach pulse on load");
    a_invalid_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.held == 3'h0 || s_q.held == 3'h7) |=> s_q.req == 6'h00)
        else $error("drive requested on invalid code");
    a_one_each: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.held_ok && s_q.held != 3'h0 && s_q.held != 3'h7) |=>
        ($onehot(s_q.req[2:0]) && $onehot(s_q.req[5:3])))
        else $error("not one low and one high drive");
    a_reset_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !s_q.held_ok |-> (low_side_drive == 3'h0 && high_side_drive_n == 3'h7))
        else $error("drive on before a code was held");

    // Timebase divider wraps once per period
    a_tick_wraps: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick |=> s_q.div == 16'h0000)
        else $error("timebase did not wrap on tick");
    a_tick_counts: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !tick |=> s_q.div == $past(s_q.div) + 16'h0001)
        else $error("timebase skipped a count");

    // Blank window length is counted in timebase ticks only
    a_blank_loaded: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(s_q.held) |-> s_q.blank == cbi_pkg::BLANK_CYCLES)
        else $error("blank window not started on load");
    a_blank_waits: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.blank != 2'h0 && !tick) |=> $stable(s_q.blank))
        else $error("blank window moved without a tick");
    a_blank_steps: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.blank != 2'h0 && tick) |=> s_q.blank == $past(s_q.blank) - 2'h1)
        else $error("blank window missed a tick");
    a_load_gated: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(s_q.held) |-> ($past(s_q.blank) == 2'h0 && !$past(tach_out)))
        else $error("latch loaded while shut");
    a_latch_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.blank == 2'h0 && !tach_out && hall == s_q.held) |=> $stable(s_q.held))
        else $error("latch moved without a sensor change");

    // Tach pulse is a fixed count from each load
    a_tach_loaded: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(s_q.held) |-> s_q.tach == 16'(TACH_CYCLES))
        else $error("tach count not loaded");
    a_tach_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tach_out |=> $stable(s_q.held))
        else $error("latch loaded during tach pulse");
    a_tach_runs: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.tach > 16'h0001) |=> tach_out)
        else $error("tach pulse ended early");
    a_tach_ends: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.tach == 16'h0001) |=> !tach_out)
        else $error("tach pulse ran long");

    // Drive requests follow the held code only
    a_req_before_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !s_q.held_ok |=> s_q.req == 6'h00)
        else $error("drive requested before a code was held");
    a_code_sticks: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_q.held_ok |=> s_q.held_ok)
        else $error("held code flag dropped");
    a_req_valid: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.held_ok && code_ok(s_q.held)) |=> s_q.req != 6'h00)
        else $error("valid code requested no drive");
    a_pins_invalid: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!code_ok(s_q.held)) [*3] |-> (low_side_drive == 3'h0 && high_side_drive_n == 3'h7))
        else $error("drive on with an invalid code");
    a_drive_from_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (drive_on & ~$past(s_q.req)) == 6'h00)
        else $error("drive on without a request");

    // Pin level checks; a shoot-through here would short the supply
    a_one_low_pin: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $onehot0(low_side_drive))
        else $error("more than one low side on");
    a_one_high_pin: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $onehot0(~high_side_drive_n))
        else $error("more than one high side on");
    a_phase_pins: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (low_side_drive & ~high_side_drive_n) == 3'h0)
        else $error("both sides of a phase on at the pins");

    // A drive may rise only after its partner stood off for the two cycles before
    a_rise_ls_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(low_side_drive[0]) |->
        ($past(high_side_drive_n[0]) && $past(high_side_drive_n[0], 2)))
        else $error("phase a low side on too soon");
    a_rise_ls_b: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(low_side_drive[1]) |->
        ($past(high_side_drive_n[1]) && $past(high_side_drive_n[1], 2)))
        else $error("phase b low side on too soon");
    a_rise_ls_c: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(low_side_drive[2]) |->
        ($past(high_side_drive_n[2]) && $past(high_side_drive_n[2], 2)))
        else $error("phase c low side on too soon");
    a_rise_hs_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(high_side_drive_n[0]) |->
        (!$past(low_side_drive[0]) && !$past(low_side_drive[0], 2)))
        else $error("phase a high side on too soon");
    a_rise_hs_b: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(high_side_drive_n[1]) |->
        (!$past(low_side_drive[1]) && !$past(low_side_drive[1], 2)))
        else $error("phase b high side on too soon");
    a_rise_hs_c: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(high_side_drive_n[2]) |->
        (!$past(low_side_drive[2]) && !$past(low_side_drive[2], 2)))
        else $error("phase c high side on too soon");

endmodule

/* tb/cbi_hall_model.sv */
`timescale 1ns/10ps
// Three position sensors around the rotor, 120 degree coding
module cbi_hall_model
(
    // Rotor step and wiring fault
    input wire logic [2:0] pos,
    input wire logic [1:0] fault,
    // Sensor lines
    output cbi_pkg::cbi_hall_t hall
);
////////////////////////////////////////////////////////////////////////////////
    // Fault 1 shorts every line low, fault 2 opens them all high
    always_comb
    begin
        case (pos)
            3'h0: hall = 3'h1;
            3'h1: hall = 3'h3;
            3'h2: hall = 3'h2;
            3'h3: hall = 3'h6;
            3'h4: hall = 3'h4;
            default: hall = 3'h5;
        endcase
        if (fault == 2'h1)
            hall = 3'h0;
        else if (fault == 2'h2)
            hall = 3'h7;
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
    localparam int unsigned DIV = 8;
    localparam int unsigned TACH = 4;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b1;
    logic dir_fwd = 1'b1;
    logic [2:0] pos = 3'h0;
    logic [1:0] fault = 2'h1;
    cbi_pkg::cbi_hall_t hall, hall_held;
    logic [2:0] low_side_drive, high_side_drive_n;
    logic tach_out;
    logic [5:0] d, prev = 6'h00;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n, r;
    int off_c[6] = '{default: -100};
////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    cbi_hall_model i_cbi_hall_model (.pos(pos), .fault(fault), .hall(hall));
    // Short counts keep the lockout and tach windows visible in a short run
    cbi_top #(.PWM_DIV(DIV), .TACH_CYCLES(TACH)) i_cbi_top (.clk_sys(clk_sys),
        .arst_n(arst_n), .hall(hall), .dir_fwd(dir_fwd), .low_side_drive(low_side_drive),
        .high_side_drive_n(high_side_drive_n), .tach_out(tach_out), .hall_held(hall_held));
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [5:0] seen, input logic [5:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Drive just after the edge so sampling never races
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask

    // Expected {high_n, low} per direction and sensor code
    function automatic logic [5:0] exp_drv(input logic dir, input logic [2:0] c);
        case ({dir, c})
            4'h9, 4'h6: return 6'h32;
            4'hb, 4'h4: return 6'h34;
            4'ha, 4'h5: return 6'h2c;
            4'he, 4'h1: return 6'h29;
            4'hc, 4'h3: return 6'h19;
            4'hd, 4'h2: return 6'h1a;
            default: return 6'h38;
        endcase
    endfunction
////////////////////////////////////////////////////////////////////////////////
    // Overlap and dead time watch on every edge
    always @(posedge clk_sys)
    begin
        cyc++;
        d = {~high_side_drive_n, low_side_drive};
        for (int i = 0; i < 6; i++)
        begin
            if (prev[i] && !d[i])
                off_c[i] = cyc;
            if (!prev[(i + 3) % 6] && d[(i + 3) % 6])
                chk("lock gap", 6'(cyc - off_c[i] > DIV), 6'h01);
        end
        chk("overlap", 6'(d[5:3] & d[2:0]), 6'h00);
        prev = d;
    end

    // Main sequence
    initial
    begin
        r = $urandom(32'haf5e3ceb);
        #2 arst_n = 1'b0; // A real fall, so the flops clear before the first edge
        tick(16);
        chk("reset drive", {high_side_drive_n, low_side_drive}, 6'h38);
        chk("reset tach", {5'h00, tach_out}, 6'h00);
        arst_n = 1'b1;
        tick(40);
        chk("idle drive", {high_side_drive_n, low_side_drive}, 6'h38);
        // Random rotation, reversals and wiring faults
        for (int k = 0; k < 60; k++)
        begin
            dir_fwd = 1'($urandom);
            pos = 3'((int'(pos) + 1 + 4 * ($urandom % 2)) % 6);
            fault = ($urandom % 8 == 0) ? 2'(1 + $urandom % 2) : 2'h0;
            tick(40);
            chk("held", {3'h0, hall_held}, {3'h0, hall});
            chk("drive", {high_side_drive_n, low_side_drive}, exp_drv(dir_fwd, hall));
        end
        for (int f = 1; f < 3; f++)
        begin
            fault = 2'(f);
            dir_fwd = f[0];
            tick(40);
            chk("bad code", {high_side_drive_n, low_side_drive}, 6'h38);
        end
        // A second change inside the blank window waits
        fault = 2'h0;
        pos = 3'h0;
        tick(40);
        pos = 3'h1;
        tick(2);
        pos = 3'h2;
        tick(6);
        chk("blanked", {3'h0, hall_held}, 6'h03);
        tick(40);
        chk("late load", {3'h0, hall_held}, 6'h02);
        // Tach pulse width
        n = 0;
        pos = 3'h3;
        repeat (20)
        begin
            tick(1);
            n += int'(tach_out);
        end
        chk("tach width", 6'(n), 6'(TACH));
        stop_test();
    end
endmodule
